// [hdl/aesb_pkg.sv]
// constants, register map and types of the single-block encrypt engine
`default_nettype none
package aesb_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_START_TASK = 12'h000;
  localparam logic [11:0] OFF_ABORT_TASK = 12'h004;
  localparam logic [11:0] OFF_DONE_FLAG  = 12'h100;
  localparam logic [11:0] OFF_ABORT_FLAG = 12'h104;
  localparam logic [11:0] OFF_IRQ_EN_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h308;
  localparam logic [11:0] OFF_STATUS     = 12'h400;
  localparam logic [11:0] OFF_STRUCT_PTR = 12'h504;

  // field positions
  localparam int TASK_BIT        = 0;
  localparam int FLAG_BIT        = 0;
  localparam int EN_DONE_BIT     = 0;
  localparam int EN_ABORT_BIT    = 1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_CORE_BIT = 1;

  // reset values
  localparam logic [31:0] PTR_RESET  = 32'h0000_0000;
  localparam logic [1:0]  EN_RESET   = 2'h0;
  localparam logic        FLAG_RESET = 1'h0;

  // in-memory structure: key, cleartext, ciphertext, 16 bytes each
  localparam logic [31:0] STRUCT_KEY_OFF    = 32'h0000_0000;
  localparam logic [31:0] STRUCT_CLEAR_OFF  = 32'h0000_0010;
  localparam logic [31:0] STRUCT_CIPHER_OFF = 32'h0000_0020;
  localparam logic [31:0] STRUCT_BYTES      = 32'h0000_0030;

  // dma beats: 8 word reads then 4 word writes
  localparam logic [3:0] BEAT_FIRST_READ  = 4'h0;
  localparam logic [3:0] BEAT_LAST_KEY    = 4'h3;
  localparam logic [3:0] BEAT_LAST_READ   = 4'h7;
  localparam logic [3:0] BEAT_FIRST_WRITE = 4'h8;
  localparam logic [3:0] BEAT_LAST_WRITE  = 4'hb;

  // timing: typical block time and the clock it is counted in
  localparam int CLK_PERIOD_NS  = 25;
  localparam int TYP_BLOCK_NS   = 6000;
  localparam int TYP_BLOCK_CYC  = TYP_BLOCK_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_ENCRYPT = 3'b010,
    ST_WRITE   = 3'b011,
    ST_DRAIN   = 3'b100
  } aesb_state_type;

endpackage
`default_nettype wire

// [hdl/aesb_block_encrypt.sv]
// single-block aes encrypt engine with apb registers, ram dma and shared core port
//
// Our own choice: the APB slave port.
`default_nettype none
module aesb_block_encrypt #(
  parameter logic [31:0] RAM_BASE = 32'h2000_0000,
  parameter logic [31:0] RAM_SIZE = 32'h0000_6000
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  // apb slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // event fabric task inputs and event outputs
  input  wire logic         startTrig,
  input  wire logic         abortTrig,
  output logic              doneEvent,
  output logic              abortEvent,
  output logic              irq,
  // data ram dma master
  output logic              dmaReq,
  output logic              dmaWrite,
  output logic      [31:0]  dmaAddr,
  output logic      [31:0]  dmaWdata,
  input  wire logic         dmaAck,
  input  wire logic [31:0]  dmaRdata,
  // shared aes core
  output logic              coreReq,
  output logic      [127:0] coreKey,
  output logic      [127:0] coreBlock,
  input  wire logic         coreBusy,
  input  wire logic         coreConflict,
  input  wire logic         coreDone,
  input  wire logic [127:0] coreResult
);

  // memory words are little-endian; aes byte 0 sits in the top byte of the block
  function automatic logic [31:0] swapBytes(input logic [31:0] w);
    swapBytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  aesb_pkg::aesb_state_type state;
  logic [3:0]   beat;
  logic [31:0]  structPtr;
  logic [31:0]  runBase;
  logic [127:0] textReg;
  logic         doneFlag;
  logic         abortFlag;
  logic [1:0]   irqEn;

  // apb decode: a transfer completes at the edge where pready is seen high
  wire apbDone   = psel & penable & pready;
  wire apbWr     = apbDone & pwrite;
  wire hitStart  = paddr == aesb_pkg::OFF_START_TASK;
  wire hitAbort  = paddr == aesb_pkg::OFF_ABORT_TASK;
  wire hitDone   = paddr == aesb_pkg::OFF_DONE_FLAG;
  wire hitErr    = paddr == aesb_pkg::OFF_ABORT_FLAG;
  wire hitEnSet  = paddr == aesb_pkg::OFF_IRQ_EN_SET;
  wire hitEnClr  = paddr == aesb_pkg::OFF_IRQ_EN_CLR;
  wire hitStatus = paddr == aesb_pkg::OFF_STATUS;
  wire hitPtr    = paddr == aesb_pkg::OFF_STRUCT_PTR;
  wire mapped    = hitStart | hitAbort | hitDone | hitErr | hitEnSet | hitEnClr
                 | hitStatus | hitPtr;

  // tasks from software or the event fabric
  wire wrBit0    = pwdata[aesb_pkg::TASK_BIT];
  wire startHit  = startTrig | (apbWr & hitStart & wrBit0);
  wire abortHit  = abortTrig | (apbWr & hitAbort & wrBit0);
  wire running   = state != aesb_pkg::ST_IDLE;

  // the whole 48-byte structure must fit in data ram before any access starts
  wire [31:0] ptrOff  = structPtr - RAM_BASE;
  wire        ptrBad  = (structPtr < RAM_BASE) | (ptrOff > (RAM_SIZE - aesb_pkg::STRUCT_BYTES));
  wire        startOk = startHit & ~running & ~coreBusy & ~ptrBad;
  wire        startNg = startHit & ~running & (coreBusy | ptrBad);

  // each beat addresses base + 4*beat, so writes land at offset 32 onward
  wire [3:0]  beatInc  = beat + 4'h1;
  wire [31:0] nextAddr = runBase + {26'h0, beatInc, 2'b00};
  wire [31:0] firstAddr = structPtr + aesb_pkg::STRUCT_KEY_OFF;
  wire        lastRead  = beat == aesb_pkg::BEAT_LAST_READ;
  wire        lastWrite = beat == aesb_pkg::BEAT_LAST_WRITE;
  wire [31:0] cipherWord0 = swapBytes(coreResult[127:96]);

  // registered event pulses feeding flags, fabric and interrupt
  logic doneSet;
  logic errSet;
  assign doneEvent  = doneSet;
  assign abortEvent = errSet;

  // engine sequencer: abort wins over progress, conflicts end the core phase
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state    <= aesb_pkg::ST_IDLE;
      beat     <= aesb_pkg::BEAT_FIRST_READ;
      runBase  <= aesb_pkg::PTR_RESET;
      dmaReq   <= 1'b0;
      dmaWrite <= 1'b0;
      dmaAddr  <= 32'h0000_0000;
      dmaWdata <= 32'h0000_0000;
      coreReq  <= 1'b0;
      doneSet  <= 1'b0;
      errSet   <= 1'b0;
    end
    else
    begin
      doneSet <= 1'b0;
      errSet  <= 1'b0;
      case (state)
        aesb_pkg::ST_IDLE:
        begin
          // abort here is ignored on purpose
          if (startOk)
          begin
            state    <= aesb_pkg::ST_READ;
            beat     <= aesb_pkg::BEAT_FIRST_READ;
            runBase  <= structPtr;
            dmaReq   <= 1'b1;
            dmaWrite <= 1'b0;
            dmaAddr  <= firstAddr;
          end
          else if (startNg)
          begin
            errSet <= 1'b1;
          end
        end
        aesb_pkg::ST_READ, aesb_pkg::ST_WRITE:
        begin
          if (abortHit)
          begin
            // a beat already on the bus is finished before the event
            if (dmaAck)
            begin
              state  <= aesb_pkg::ST_IDLE;
              dmaReq <= 1'b0;
              errSet <= 1'b1;
            end
            else
            begin
              state <= aesb_pkg::ST_DRAIN;
            end
          end
          else if (dmaAck)
          begin
            if (state == aesb_pkg::ST_READ && lastRead)
            begin
              state   <= aesb_pkg::ST_ENCRYPT;
              dmaReq  <= 1'b0;
              coreReq <= 1'b1;
            end
            else if (state == aesb_pkg::ST_WRITE && lastWrite)
            begin
              state   <= aesb_pkg::ST_IDLE;
              dmaReq  <= 1'b0;
              doneSet <= 1'b1;
            end
            else
            begin
              beat     <= beatInc;
              dmaAddr  <= nextAddr;
              // write beats 9..11 map to words 1..3; the low bits keep the select in range
              dmaWdata <= swapBytes(textReg[127 - 32 * beatInc[1:0] -: 32]);
            end
          end
        end
        aesb_pkg::ST_ENCRYPT:
        begin
          // this unit always yields the core to the others
          if (abortHit | coreConflict)
          begin
            state   <= aesb_pkg::ST_IDLE;
            coreReq <= 1'b0;
            errSet  <= 1'b1;
          end
          else if (coreDone)
          begin
            state    <= aesb_pkg::ST_WRITE;
            coreReq  <= 1'b0;
            beat     <= aesb_pkg::BEAT_FIRST_WRITE;
            dmaReq   <= 1'b1;
            dmaWrite <= 1'b1;
            dmaAddr  <= runBase + aesb_pkg::STRUCT_CIPHER_OFF;
            dmaWdata <= cipherWord0;
          end
        end
        aesb_pkg::ST_DRAIN:
        begin
          if (dmaAck)
          begin
            state  <= aesb_pkg::ST_IDLE;
            dmaReq <= 1'b0;
            errSet <= 1'b1;
          end
        end
        default:
        begin
          state  <= aesb_pkg::ST_IDLE;
          dmaReq <= 1'b0;
        end
      endcase
    end
  end

  // read data capture: key words first, then cleartext
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      coreKey   <= 128'h0;
      coreBlock <= 128'h0;
      textReg   <= 128'h0;
    end
    else if (state == aesb_pkg::ST_READ && dmaAck && !dmaWrite)
    begin
      if (beat <= aesb_pkg::BEAT_LAST_KEY)
        coreKey[127 - 32 * beat[1:0] -: 32] <= swapBytes(dmaRdata);
      else
        coreBlock[127 - 32 * beat[1:0] -: 32] <= swapBytes(dmaRdata);
    end
    else if (state == aesb_pkg::ST_ENCRYPT && coreDone && !abortHit && !coreConflict)
    begin
      textReg <= coreResult;
    end
  end

  // event flags: hardware set wins over a software clear in the same cycle
  wire clrDone = apbWr & hitDone & ~pwdata[aesb_pkg::FLAG_BIT];
  wire clrErr  = apbWr & hitErr & ~pwdata[aesb_pkg::FLAG_BIT];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      doneFlag  <= aesb_pkg::FLAG_RESET;
      abortFlag <= aesb_pkg::FLAG_RESET;
    end
    else
    begin
      doneFlag  <= doneSet | (doneFlag & ~clrDone);
      abortFlag <= errSet | (abortFlag & ~clrErr);
    end
  end

  // interrupt enables and the level interrupt line
  wire [1:0] enSetBits = (apbWr & hitEnSet) ? pwdata[1:0] : 2'h0;
  wire [1:0] enClrBits = (apbWr & hitEnClr) ? pwdata[1:0] : 2'h0;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irqEn <= aesb_pkg::EN_RESET;
      irq   <= 1'b0;
    end
    else
    begin
      irqEn <= (irqEn | enSetBits) & ~enClrBits;
      irq   <= |({abortFlag, doneFlag} & irqEn);
    end
  end

  // structure pointer; a change mid-run does not disturb the run
  always_ff @(posedge mclk)
  begin
    if (rst)
      structPtr <= aesb_pkg::PTR_RESET;
    else if (apbWr & hitPtr)
      structPtr <= pwdata;
  end

  // read mux; task registers read as zero
  wire [31:0] statusWord = {30'h0, coreReq, running};
  wire [31:0] rdMux = hitDone   ? {31'h0, doneFlag}
                    : hitErr    ? {31'h0, abortFlag}
                    : (hitEnSet | hitEnClr) ? {30'h0, irqEn}
                    : hitStatus ? statusWord
                    : hitPtr    ? structPtr
                    : 32'h0000_0000;

  // apb answer: one wait state, then pready with data or an error for holes
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // checks
  localparam int TypCycles = aesb_pkg::TYP_BLOCK_CYC;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_done_after_write: assert property (
    doneSet |-> $past(state == aesb_pkg::ST_WRITE && dmaAck && lastWrite))
    else $error("done event without final ciphertext write");

  a_fetch_before_core: assert property (
    $rose(coreReq) |-> $past(state == aesb_pkg::ST_READ && dmaAck && lastRead))
    else $error("core started before key and cleartext fetched");

  a_abort_running: assert property (
    (state == aesb_pkg::ST_ENCRYPT && abortHit) |=> errSet && !coreReq
      ##1 abortFlag)
    else $error("abort during encrypt did not raise error");

  a_conflict_yield: assert property (
    (state == aesb_pkg::ST_ENCRYPT && coreConflict) |=> errSet && state == aesb_pkg::ST_IDLE)
    else $error("core conflict did not abort");

  a_busy_start: assert property (
    (startHit && !running && coreBusy) |=> errSet && !dmaReq && !running)
    else $error("start with busy core was not refused");

  a_dma_window: assert property (
    dmaReq |-> dmaAddr >= RAM_BASE && dmaAddr - RAM_BASE < RAM_SIZE)
    else $error("dma address outside data ram");

  a_events_quiet: assert property (
    (doneSet || errSet) |-> !dmaReq)
    else $error("event raised with dma pending");

  a_write_place: assert property (
    (dmaReq && dmaWrite) |-> dmaAddr - runBase >= aesb_pkg::STRUCT_CIPHER_OFF
      && dmaAddr - runBase < aesb_pkg::STRUCT_BYTES)
    else $error("ciphertext written outside its slot");

  a_idle_abort: assert property (
    (abortHit && !running && !startHit) |=> !errSet)
    else $error("idle abort raised error");

  a_flag_clear: assert property (
    (clrDone && !doneSet) |=> !doneFlag)
    else $error("done flag not cleared by writing zero");

  a_enable_set: assert property (
    (apbWr && hitEnSet && pwdata[aesb_pkg::EN_ABORT_BIT]) |=> irqEn[aesb_pkg::EN_ABORT_BIT])
    else $error("enable set write lost");

  a_enable_clear: assert property (
    (apbWr && hitEnClr && pwdata[aesb_pkg::EN_DONE_BIT]) |=> !irqEn[aesb_pkg::EN_DONE_BIT])
    else $error("enable clear write lost");

  c_full_block: cover property (
    startOk ##[1:TypCycles] doneSet);
  c_abort_read: cover property (state == aesb_pkg::ST_DRAIN ##[1:20] errSet);
  c_conflict: cover property (state == aesb_pkg::ST_ENCRYPT && coreConflict);
  c_busy_refuse: cover property (startNg && coreBusy);

endmodule
`default_nettype wire

// [tb/aesb_mem_model.sv]
// data ram and shared aes core model facing the engine's dma and core ports
`default_nettype none
module aesb_mem_model #(
  parameter logic [31:0] RAM_BASE = 32'h2000_0000,
  parameter logic [31:0] RAM_SIZE = 32'h0000_6000
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         slow,
  input  wire logic         dmaReq,
  input  wire logic         dmaWrite,
  input  wire logic [31:0]  dmaAddr,
  input  wire logic [31:0]  dmaWdata,
  output logic              dmaAck,
  output logic      [31:0]  dmaRdata,
  input  wire logic         coreReq,
  input  wire logic [127:0] coreKey,
  input  wire logic [127:0] coreBlock,
  output logic              coreDone,
  output logic      [127:0] coreResult,
  output int                badCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:63];
  int          waitCnt;
  int          coreCnt;

  // ram answers at once or after 3 stalls; idle read data flips so stale words never match
  always @(posedge mclk)
  begin
    dmaAck <= 1'b0;
    dmaRdata <= ~dmaRdata;
    if (rst)
    begin
      dmaRdata <= 32'h0;
      waitCnt <= 0;
      badCnt <= 0;
    end
    else if (dmaReq && !dmaAck)
    begin
      if (dmaAddr < RAM_BASE || dmaAddr >= RAM_BASE + RAM_SIZE || dmaAddr[1:0] != 2'h0)
        badCnt <= badCnt + 1;
      if (waitCnt >= (slow ? 3 : 0))
      begin
        waitCnt <= 0;
        dmaAck <= 1'b1;
        if (dmaWrite)
          mem[dmaAddr[7:2]] <= dmaWdata;
        else
          dmaRdata <= mem[dmaAddr[7:2]];
      end
      else
        waitCnt <= waitCnt + 1;
    end
  end

  // stand-in cipher: a keyed xor, enough to prove key, block and result paths
  always @(posedge mclk)
  begin
    coreDone <= 1'b0;
    coreResult <= ~coreResult;
    if (rst || !coreReq)
      coreCnt <= 0;
    else if (!coreDone)
    begin
      coreCnt <= coreCnt + 1;
      if (coreCnt == (slow ? 20 : 5))
      begin
        coreDone <= 1'b1;
        coreResult <= coreKey ^ coreBlock ^ {4{32'h5a5a_c3c3}};
      end
    end
  end
endmodule
`default_nettype wire

// [tb/aes_block_encrypt_dma_tb_top.sv]
// self-checking bench of the single-block encrypt engine
`default_nettype none
module aes_block_encrypt_dma_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PTR = 32'h2000_0040;
  logic         mclk, rst, psel, penable, pwrite, pready, pslverr, rerr, slow;
  logic         startTrig, abortTrig, doneEvent, abortEvent, irq;
  logic         dmaReq, dmaWrite, dmaAck, coreReq, coreBusy, coreConflict, coreDone;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, dmaAddr, dmaWdata, dmaRdata, rdat;
  logic [127:0] coreKey, coreBlock, coreResult;
  int           errors, checked, nDone, nAbort, nBeats, cycles, badCnt, d0, a0, b0;

  aesb_block_encrypt dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .startTrig, .abortTrig, .doneEvent, .abortEvent, .irq, .dmaReq,
    .dmaWrite, .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata, .coreReq, .coreKey, .coreBlock,
    .coreBusy, .coreConflict, .coreDone, .coreResult);
  aesb_mem_model model (.mclk, .rst, .slow, .dmaReq, .dmaWrite, .dmaAddr, .dmaWdata,
    .dmaAck, .dmaRdata, .coreReq, .coreKey, .coreBlock, .coreDone, .coreResult, .badCnt);

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] kw(input int i);
    return 32'h1357_9bdf + 32'h0f0f_1111 * i;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // event and beat counters; events must find the dma quiet; watchdog
  always @(posedge mclk)
  begin
    cycles++;
    if (doneEvent === 1'b1) nDone++;
    if (abortEvent === 1'b1) nAbort++;
    if ((dmaReq & dmaAck) === 1'b1) nBeats++;
    if ((doneEvent | abortEvent) === 1'b1) check("dma idle", 32'h0, {31'h0, dmaReq});
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end

  // apb master: request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no wait count is assumed; only the watchdog ends a stalled access
    do
    begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic prep();
    for (int i = 0; i < 12; i++) model.mem[16 + i] = (i < 8) ? kw(i) : 32'hdead_beef;
    apb(1'b1, aesb_pkg::OFF_STRUCT_PTR, PTR);
  endtask

  task automatic start(input logic viaTrig);
    d0 = nDone;
    a0 = nAbort;
    b0 = nBeats;
    if (viaTrig)
    begin
      @(posedge mclk);
      startTrig <= 1'b1;
      @(posedge mclk);
      startTrig <= 1'b0;
    end
    else
      apb(1'b1, aesb_pkg::OFF_START_TASK, 32'h1);
  endtask

  task automatic expectEv(input int dn, input int ab);
    int k;
    k = 0;
    while (nDone + nAbort == d0 + a0 && k < 3000)
    begin
      @(posedge mclk);
      k++;
    end
    repeat (4) @(posedge mclk);
    check("done events", dn, nDone - d0);
    check("abort events", ab, nAbort - a0);
  endtask

  task automatic waitCore();
    int k;
    k = 0;
    while (coreReq !== 1'b1 && k < 500)
    begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic t_regs();
    logic [11:0] offs [7];
    offs = '{aesb_pkg::OFF_START_TASK, aesb_pkg::OFF_ABORT_TASK, aesb_pkg::OFF_DONE_FLAG,
      aesb_pkg::OFF_ABORT_FLAG, aesb_pkg::OFF_IRQ_EN_SET, aesb_pkg::OFF_IRQ_EN_CLR,
      aesb_pkg::OFF_STRUCT_PTR};
    foreach (offs[i])
    begin
      apb(1'b0, offs[i], 32'h0);
      check("reset value", 32'h0, rdat);
    end
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_SET, 32'h3);
    apb(1'b0, aesb_pkg::OFF_IRQ_EN_CLR, 32'h0);
    check("enables", 32'h3, rdat);
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_CLR, 32'h1);
    apb(1'b0, aesb_pkg::OFF_IRQ_EN_SET, 32'h0);
    check("enables", 32'h2, rdat);
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_CLR, 32'h0);
    apb(1'b0, aesb_pkg::OFF_IRQ_EN_CLR, 32'h0);
    check("enables", 32'h2, rdat);
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_CLR, 32'h2);
    apb(1'b1, aesb_pkg::OFF_STRUCT_PTR, 32'h2000_0abc);
    apb(1'b0, aesb_pkg::OFF_STRUCT_PTR, 32'h0);
    check("pointer", 32'h2000_0abc, rdat);
    $display("test regs finished");
  endtask

  task automatic t_encrypt(input logic viaTrig, input logic slowMode);
    int t0;
    slow <= slowMode;
    prep();
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_SET, 32'h1);
    t0 = cycles;
    start(viaTrig);
    expectEv(1, 0);
    if (!slowMode) check("block time", 32'h1, {31'h0, (cycles - t0) < aesb_pkg::TYP_BLOCK_CYC});
    // the core pattern lands byte-reversed in little-endian memory words
    for (int i = 0; i < 4; i++) check("cipher", kw(i) ^ kw(i + 4) ^ 32'hc3c3_5a5a, model.mem[24 + i]);
    check("dma window", 32'h0, badCnt);
    check("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, aesb_pkg::OFF_DONE_FLAG, 32'h1);
    apb(1'b0, aesb_pkg::OFF_DONE_FLAG, 32'h0);
    check("done flag", 32'h1, rdat);
    apb(1'b1, aesb_pkg::OFF_DONE_FLAG, 32'h0);
    apb(1'b0, aesb_pkg::OFF_DONE_FLAG, 32'h0);
    check("done flag cleared", 32'h0, rdat);
    check("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_CLR, 32'h3);
    $display("test encrypt finished");
  endtask

  task automatic t_abort(input logic viaTrig, input logic inCore);
    slow <= 1'b1;
    prep();
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_SET, 32'h2);
    start(1'b0);
    if (inCore) waitCore();
    else repeat (3) @(posedge mclk);
    if (viaTrig)
    begin
      abortTrig <= 1'b1;
      @(posedge mclk);
      abortTrig <= 1'b0;
    end
    else
      apb(1'b1, aesb_pkg::OFF_ABORT_TASK, 32'h1);
    expectEv(0, 1);
    check("core released", 32'h0, {31'h0, coreReq});
    check("irq on", 32'h1, {31'h0, irq});
    apb(1'b0, aesb_pkg::OFF_ABORT_FLAG, 32'h0);
    check("abort flag", 32'h1, rdat);
    apb(1'b1, aesb_pkg::OFF_ABORT_FLAG, 32'h0);
    apb(1'b1, aesb_pkg::OFF_IRQ_EN_CLR, 32'h3);
    a0 = nAbort;
    apb(1'b1, aesb_pkg::OFF_ABORT_TASK, 32'h1);
    repeat (10) @(posedge mclk);
    check("idle abort", a0, nAbort);
    $display("test abort finished");
  endtask

  task automatic t_busy();
    slow <= 1'b0;
    coreBusy <= 1'b1;
    prep();
    start(1'b1);
    expectEv(0, 1);
    check("dma beats", 32'h0, nBeats - b0);
    coreBusy <= 1'b0;
    apb(1'b1, aesb_pkg::OFF_STRUCT_PTR, 32'h1000_0000);
    start(1'b0);
    expectEv(0, 1);
    check("dma beats bad pointer", 32'h0, nBeats - b0);
    $display("test busy finished");
  endtask

  task automatic t_conflict();
    slow <= 1'b1;
    prep();
    start(1'b0);
    waitCore();
    apb(1'b0, aesb_pkg::OFF_STATUS, 32'h0);
    check("status running", 32'h3, rdat);
    coreConflict <= 1'b1;
    @(posedge mclk);
    coreConflict <= 1'b0;
    expectEv(0, 1);
    check("core released", 32'h0, {31'h0, coreReq});
    $display("test conflict finished");
  endtask

  // reset in the middle of a run must leave the engine idle and silent
  task automatic t_reset();
    slow <= 1'b1;
    prep();
    start(1'b0);
    waitCore();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, aesb_pkg::OFF_STATUS, 32'h0);
    check("status after reset", 32'h0, rdat);
    check("events after reset", 32'h0, nDone + nAbort - d0 - a0);
    $display("test reset finished");
  endtask

  initial
  begin
    {rst, psel, penable, pwrite, startTrig, abortTrig, coreBusy, coreConflict, slow} = 9'h100;
    paddr = 12'h0;
    pwdata = 32'h0;
    {errors, checked, nDone, nAbort, nBeats, cycles} = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_encrypt(1'b0, 1'b0);
    t_encrypt(1'b1, 1'b1);
    t_abort(1'b0, 1'b0);
    t_abort(1'b1, 1'b1);
    t_busy();
    t_conflict();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
